// ---- hdl/tzx_cfg.svh ----
// constants for the table access / xor / skip execution block
`ifndef TZX_CFG_SVH
`define TZX_CFG_SVH

`define TZX_PTR_W        21
`define TZX_FA_W         12
`define TZX_APB_AW       8

// four-phase instruction cycle
`define TZX_Q1           2'h0
`define TZX_Q4           2'h3

// opcode patterns
`define TZX_TBL_RD_HI    14'h0002
`define TZX_TBL_WT_HI    14'h0003
`define TZX_XOR_LIT_HI   8'h0A
`define TZX_XOR_FILE_HI  6'h06
`define TZX_TEST_ZERO_HI 7'h33
`define TZX_DEST_BIT     9
`define TZX_BANK_BIT     8

// pointer step modes
`define TZX_STEP_NONE    2'h0
`define TZX_STEP_POSTINC 2'h1
`define TZX_STEP_POSTDEC 2'h2
`define TZX_STEP_PREINC  2'h3

// shared access window split
`define TZX_ACC_SPLIT    8'h80
`define TZX_ACC_LO_BANK  4'h0
`define TZX_ACC_HI_BANK  4'hF

// register byte offsets
`define TZX_REG_CTRL     8'h00
`define TZX_REG_STATUS   8'h04
`define TZX_REG_PTR      8'h08
`define TZX_REG_LATCH    8'h0C
`define TZX_REG_ACC      8'h10
`define TZX_REG_FLAGS    8'h14
`define TZX_REG_BANK     8'h18
`define TZX_REG_SKIPCNT  8'h1C
`define TZX_HOLD_SEL     3'h1

// field positions
`define TZX_CTRL_RUN     0
`define TZX_FLAG_Z       0
`define TZX_FLAG_N       1
`define TZX_STAT_BUSY    0
`define TZX_STAT_ILLEGAL 3

// reset values
`define TZX_RST_RUN      1'h1
`define TZX_RST_PTR      21'h000000
`define TZX_RST_BYTE     8'h00
`define TZX_RST_BANK     4'h0

`endif

// ---- hdl/tzx_core.sv ----
// execution of table read/write, test-skip and xor instructions
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tzx_cfg.svh"

// Overview of operation
// - mode 0 none, 1 post+, 2 post-, 3 pre+
// - read fetches byte into latch, pre+ first
// - pointer is 21-bit byte address
// - pointer bit0 picks low or high byte
// - write stores latch in holding slot ptr[2:0]
// - write mode field, pre+ before holding write
// - zero test discards next word, two cycles
// - skipping a two-word instruction takes three
// - bank bit 0 uses shared window
// - xor literal into accumulator, sets N Z
// - xor file register, one cycle, sets N Z
// - dest bit 0 accumulator, 1 file register
// - xor file opcode 000110 d a f
module tzx_core
    import tzx_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`TZX_APB_AW-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // instruction stream
    input  wire logic                  instr_valid,
    input  wire logic [15:0]           instr_word,
    input  wire logic                  instr_two_word,
    output logic                       instr_take,
    output logic                       skip_pulse,
    // program memory read port
    output logic [`TZX_PTR_W-2:0]      pm_addr,
    output logic                       pm_re,
    input  wire logic [15:0]           pm_rdata,
    // file register port
    output logic [`TZX_FA_W-1:0]       fr_addr,
    output logic                       fr_re,
    output logic                       fr_we,
    output logic [7:0]                 fr_wdata,
    input  wire logic [7:0]            fr_rdata,
    // holding register write strobe
    output logic                       hold_we,
    output logic [2:0]                 hold_idx,
    output logic [7:0]                 hold_data
);
    tzx_state_s s_r;
    tzx_state_s s_nxt;
    logic       take;
    logic       apb_setup;
    logic       apb_write;
    logic [7:0] res;
    logic       is_rd;
    logic       is_wt;
    logic       is_xor_lit;
    logic       is_xor_file;
    logic       is_tst;
    logic       in_file;

    tzx_step_if #(.PTR_W(`TZX_PTR_W)) step_bus ();

    tzx_ptr_step u_step
    (
        .sif (step_bus)
    );

    assign step_bus.ptr  = s_r.ptr;
    assign step_bus.mode = s_r.instr[1:0];
    assign step_bus.pre  = (s_r.st == TZX_ST_EXEC);

    // decode of the held instruction
    assign is_rd       = (s_r.instr[15:2] == `TZX_TBL_RD_HI);
    assign is_wt       = (s_r.instr[15:2] == `TZX_TBL_WT_HI);
    assign is_xor_lit  = (s_r.instr[15:8] == `TZX_XOR_LIT_HI);
    assign is_xor_file = (s_r.instr[15:10] == `TZX_XOR_FILE_HI);
    assign is_tst      = (s_r.instr[15:9] == `TZX_TEST_ZERO_HI);

    // file operand needed by the incoming word
    assign in_file  = (instr_word[15:10] == `TZX_XOR_FILE_HI)
                   || (instr_word[15:9] == `TZX_TEST_ZERO_HI);

    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;

    // file address of the incoming word
    function automatic logic [`TZX_FA_W-1:0] file_addr
    (
        input logic [15:0] w,
        input logic [3:0]  bank
    );
        logic [7:0] f;
        f = w[7:0];
        if (w[`TZX_BANK_BIT])
            file_addr = {bank, f};
        else if (f < `TZX_ACC_SPLIT)
            file_addr = {`TZX_ACC_LO_BANK, f};
        else
            file_addr = {`TZX_ACC_HI_BANK, f};
    endfunction

    // read value of a register word
    function automatic logic [31:0] reg_read
    (
        input tzx_state_s       st,
        input logic [7:0]       a
    );
        reg_read = 32'h0000_0000;
        if (a == `TZX_REG_CTRL)
            reg_read[`TZX_CTRL_RUN] = st.run;
        else if (a == `TZX_REG_STATUS)
        begin
            reg_read[`TZX_STAT_BUSY] = st.busy || (st.st != TZX_ST_EXEC);
            reg_read[2:1] = st.st;
            reg_read[`TZX_STAT_ILLEGAL] = st.illegal;
        end
        else if (a == `TZX_REG_PTR)
            reg_read[`TZX_PTR_W-1:0] = st.ptr;
        else if (a == `TZX_REG_LATCH)
            reg_read[7:0] = st.lat;
        else if (a == `TZX_REG_ACC)
            reg_read[7:0] = st.acc;
        else if (a == `TZX_REG_FLAGS)
        begin
            reg_read[`TZX_FLAG_Z] = st.flag_z;
            reg_read[`TZX_FLAG_N] = st.flag_n;
        end
        else if (a == `TZX_REG_BANK)
            reg_read[3:0] = st.bank_sel;
        else if (a == `TZX_REG_SKIPCNT)
            reg_read[7:0] = st.skip_cnt;
        else if (a[7:5] == `TZX_HOLD_SEL)
            reg_read[7:0] = st.hold[a[4:2]];
    endfunction

    // whether an address is mapped
    function automatic logic reg_mapped
    (
        input logic [7:0] a,
        input logic       wr
    );
        if (a[1:0] != 2'h0)
            reg_mapped = 1'b0;
        else if (a == `TZX_REG_CTRL || a == `TZX_REG_PTR
              || a == `TZX_REG_LATCH || a == `TZX_REG_ACC
              || a == `TZX_REG_FLAGS || a == `TZX_REG_BANK)
            reg_mapped = 1'b1;
        else if (a == `TZX_REG_STATUS || a == `TZX_REG_SKIPCNT)
            reg_mapped = 1'b1;
        else if (a[7:5] == `TZX_HOLD_SEL)
            reg_mapped = !wr;
        else
            reg_mapped = 1'b0;
    endfunction

    always_comb
    begin
        s_nxt = s_r;
        take  = 1'b0;
        res   = 8'h00;
        s_nxt.q          = s_r.q + 2'h1;
        s_nxt.fr_we      = 1'b0;
        s_nxt.hold_we    = 1'b0;
        s_nxt.skip_pulse = 1'b0;

        // register read data and error are latched in the setup cycle
        if (apb_setup)
        begin
            s_nxt.prdata  = reg_read(s_r, paddr);
            s_nxt.pslverr = !reg_mapped(paddr, pwrite);
        end

        // software writes; the instruction logic below wins a collision
        if (apb_write)
        begin
            if (paddr == `TZX_REG_CTRL)
                s_nxt.run = pwdata[`TZX_CTRL_RUN];
            else if (paddr == `TZX_REG_STATUS)
            begin
                if (pwdata[`TZX_STAT_ILLEGAL])
                    s_nxt.illegal = 1'b0;
            end
            else if (paddr == `TZX_REG_PTR)
                s_nxt.ptr = pwdata[`TZX_PTR_W-1:0];
            else if (paddr == `TZX_REG_LATCH)
                s_nxt.lat = pwdata[7:0];
            else if (paddr == `TZX_REG_ACC)
                s_nxt.acc = pwdata[7:0];
            else if (paddr == `TZX_REG_FLAGS)
            begin
                s_nxt.flag_z = pwdata[`TZX_FLAG_Z];
                s_nxt.flag_n = pwdata[`TZX_FLAG_N];
            end
            else if (paddr == `TZX_REG_BANK)
                s_nxt.bank_sel = pwdata[3:0];
            else if (paddr == `TZX_REG_SKIPCNT)
                s_nxt.skip_cnt = `TZX_RST_BYTE;
        end

        // phase one: accept a new word, or swallow a skipped one
        if (s_r.q == `TZX_Q1)
        begin
            case (s_r.st)
                TZX_ST_EXEC:
                begin
                    if (s_r.run && instr_valid)
                    begin
                        take          = 1'b1;
                        s_nxt.busy    = 1'b1;
                        s_nxt.instr   = instr_word;
                        s_nxt.fr_addr = file_addr(instr_word, s_r.bank_sel);
                        s_nxt.fr_re   = in_file;
                    end
                end
                TZX_ST_SKIP1:
                begin
                    take           = instr_valid;
                    s_nxt.skip_two = instr_valid && instr_two_word;
                end
                TZX_ST_SKIP2:
                    take = instr_valid;
                default:
                    take = 1'b0;
            endcase
        end

        // phase four: execute
        if (s_r.q == `TZX_Q4)
        begin
            s_nxt.fr_re = 1'b0;
            case (s_r.st)
                TZX_ST_EXEC:
                begin
                    if (s_r.busy)
                    begin
                        s_nxt.busy = 1'b0;
                        if (is_rd || is_wt)
                        begin
                            s_nxt.ptr   = step_bus.nxt;
                            s_nxt.st    = TZX_ST_TBL2;
                            s_nxt.pm_re = is_rd;
                        end
                        else if (is_xor_lit)
                        begin
                            res          = s_r.acc ^ s_r.instr[7:0];
                            s_nxt.acc    = res;
                            s_nxt.flag_z = (res == 8'h00);
                            s_nxt.flag_n = res[7];
                        end
                        else if (is_xor_file)
                        begin
                            res = s_r.acc ^ fr_rdata;
                            if (s_r.instr[`TZX_DEST_BIT])
                            begin
                                s_nxt.fr_we    = 1'b1;
                                s_nxt.fr_wdata = res;
                            end
                            else
                                s_nxt.acc = res;
                            s_nxt.flag_z = (res == 8'h00);
                            s_nxt.flag_n = res[7];
                        end
                        else if (is_tst)
                        begin
                            // flags stay untouched here
                            if (fr_rdata == 8'h00)
                            begin
                                s_nxt.st         = TZX_ST_SKIP1;
                                s_nxt.skip_pulse = 1'b1;
                                s_nxt.skip_cnt   = s_r.skip_cnt + 8'h01;
                            end
                        end
                        else
                            s_nxt.illegal = 1'b1;
                    end
                end
                TZX_ST_TBL2:
                begin
                    s_nxt.ptr   = step_bus.nxt;
                    s_nxt.pm_re = 1'b0;
                    s_nxt.st    = TZX_ST_EXEC;
                    if (is_rd)
                    begin
                        if (s_r.ptr[0])
                            s_nxt.lat = pm_rdata[15:8];
                        else
                            s_nxt.lat = pm_rdata[7:0];
                    end
                    else
                    begin
                        s_nxt.hold[s_r.ptr[2:0]] = s_r.lat;
                        s_nxt.hold_we   = 1'b1;
                        s_nxt.hold_idx  = s_r.ptr[2:0];
                        s_nxt.hold_data = s_r.lat;
                    end
                end
                TZX_ST_SKIP1:
                begin
                    if (s_r.skip_two)
                        s_nxt.st = TZX_ST_SKIP2;
                    else
                        s_nxt.st = TZX_ST_EXEC;
                    s_nxt.skip_two = 1'b0;
                end
                TZX_ST_SKIP2:
                    s_nxt.st = TZX_ST_EXEC;
                default:
                    s_nxt.st = TZX_ST_EXEC;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s_r          <= '0;
            s_r.st       <= TZX_ST_EXEC;
            s_r.run      <= `TZX_RST_RUN;
            s_r.ptr      <= `TZX_RST_PTR;
            s_r.lat      <= `TZX_RST_BYTE;
            s_r.acc      <= `TZX_RST_BYTE;
            s_r.bank_sel <= `TZX_RST_BANK;
            s_r.skip_cnt <= `TZX_RST_BYTE;
        end
        else
            s_r <= s_nxt;
    end

    // outputs
    assign pready     = psel && penable;
    assign prdata     = s_r.prdata;
    assign pslverr    = s_r.pslverr && psel && penable;
    assign instr_take = take;
    assign skip_pulse = s_r.skip_pulse;
    assign pm_addr    = s_r.ptr[`TZX_PTR_W-1:1];
    assign pm_re      = s_r.pm_re;
    assign fr_addr    = s_r.fr_addr;
    assign fr_re      = s_r.fr_re;
    assign fr_we      = s_r.fr_we;
    assign fr_wdata   = s_r.fr_wdata;
    assign hold_we    = s_r.hold_we;
    assign hold_idx   = s_r.hold_idx;
    assign hold_data  = s_r.hold_data;
endmodule

`default_nettype wire

// ---- hdl/tzx_pkg.sv ----
// types for the table access / xor / skip execution block
`include "tzx_cfg.svh"

package tzx_pkg;

    typedef enum logic [1:0]
    {
        TZX_ST_EXEC,
        TZX_ST_TBL2,
        TZX_ST_SKIP1,
        TZX_ST_SKIP2
    } tzx_state_e;

    typedef struct packed
    {
        logic [1:0]                q;
        tzx_state_e                st;
        logic                      run;
        logic                      busy;
        logic [15:0]               instr;
        logic                      skip_two;
        logic [`TZX_PTR_W-1:0]     ptr;
        logic [7:0]                lat;
        logic [7:0]                acc;
        logic                      flag_n;
        logic                      flag_z;
        logic [3:0]                bank_sel;
        logic [7:0][7:0]           hold;
        logic [`TZX_FA_W-1:0]      fr_addr;
        logic                      fr_re;
        logic                      fr_we;
        logic [7:0]                fr_wdata;
        logic                      pm_re;
        logic                      hold_we;
        logic [2:0]                hold_idx;
        logic [7:0]                hold_data;
        logic                      skip_pulse;
        logic [7:0]                skip_cnt;
        logic                      illegal;
        logic [31:0]               prdata;
        logic                      pslverr;
    } tzx_state_s;

endpackage

// ---- hdl/tzx_ptr_step.sv ----
// table pointer update for the first and second instruction cycle
`timescale 1ns/1ps
`default_nettype none
`include "tzx_cfg.svh"

module tzx_ptr_step
    import tzx_pkg::*;
(
    tzx_step_if.step sif
);
    always_comb
    begin
        sif.nxt = sif.ptr;
        if (sif.pre)
        begin
            if (sif.mode == `TZX_STEP_PREINC)
                sif.nxt = sif.ptr + 1'b1;
        end
        else
        begin
            if (sif.mode == `TZX_STEP_POSTINC)
                sif.nxt = sif.ptr + 1'b1;
            else if (sif.mode == `TZX_STEP_POSTDEC)
                sif.nxt = sif.ptr - 1'b1;
        end
    end
endmodule

`default_nettype wire

// ---- hdl/tzx_step_if.sv ----
// pointer step request and result between core and stepper
`timescale 1ns/1ps
`default_nettype none

interface tzx_step_if #(parameter int PTR_W = 21);
    logic [PTR_W-1:0] ptr;
    logic [1:0]       mode;
    logic             pre;
    logic [PTR_W-1:0] nxt;

    modport core (output ptr, output mode, output pre, input nxt);
    modport step (input ptr, input mode, input pre, output nxt);
endinterface

`default_nettype wire

// ---- tb/tzx_core_assertions.sv ----
// port-level checker for the table access / xor / skip execution block
`timescale 1ns/1ps
`default_nettype none
`include "tzx_cfg.svh"

module tzx_core_assertions
(
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    // watched outputs
    input wire logic                  instr_take,
    input wire logic                  skip_pulse,
    input wire logic [`TZX_PTR_W-2:0] pm_addr,
    input wire logic                  pm_re,
    input wire logic                  fr_re,
    input wire logic                  fr_we,
    input wire logic                  hold_we
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    pm_read_len_a:
        assert property ($rose(pm_re) |-> pm_re[*4] ##1 !pm_re)
        else $error("program read strobe not four cycles");
    pm_addr_hold_a:
        assert property (pm_re && $past(pm_re) |-> $stable(pm_addr))
        else $error("program address moved during read");
    pm_quiet_a:
        assert property (pm_re |-> !fr_re && !fr_we && !hold_we)
        else $error("other access during program read");
    hold_pulse_a:
        assert property (hold_we |=> !hold_we)
        else $error("holding write longer than one cycle");
    fr_read_len_a:
        assert property ($rose(fr_re) |-> fr_re[*3] ##1 !fr_re)
        else $error("file read strobe not three cycles");
    fr_write_src_a:
        assert property (fr_we |-> $past(fr_re) && !fr_re)
        else $error("file write without preceding read");
    fr_pulse_a:
        assert property (fr_we |=> !fr_we)
        else $error("file write longer than one cycle");
    take_gap_a:
        assert property (instr_take |=> !instr_take[*3])
        else $error("instructions taken closer than four clocks");
    skip_gap_a:
        assert property (skip_pulse |=> !skip_pulse[*3])
        else $error("skip pulse repeated within a cycle");
endmodule

bind tzx_core tzx_core_assertions i_tzx_core_assertions
(
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .instr_take (instr_take),
    .skip_pulse (skip_pulse),
    .pm_addr    (pm_addr),
    .pm_re      (pm_re),
    .fr_re      (fr_re),
    .fr_we      (fr_we),
    .hold_we    (hold_we)
);

`default_nettype wire

// ---- tb/tzx_core_bench.sv ----
// self-checking bench for the table access / xor / skip execution block
`timescale 1ns/1ps
`default_nettype none
`include "tzx_cfg.svh"

module tzx_core_bench;
    typedef struct packed
    {
        logic [15:0] w;
        logic [7:0]  a0;
        logic [7:0]  acc;
        logic [7:0]  fr;
        logic [1:0]  fl;
        logic [11:0] ad;
    } tzx_row_s;

    logic        core_clk;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0;
    logic        instr_two_word = 1'b0;
    logic        pready, pslverr, instr_take, skip_pulse, pm_re;
    logic        fr_re, fr_we, hold_we;
    logic [31:0] prdata;
    logic [19:0] pm_addr;
    logic [15:0] pm_rdata;
    logic [11:0] fr_addr;
    logic [7:0]  fr_wdata, fr_rdata, hold_data;
    logic [2:0]  hold_idx;
    int          err_count = 0;
    int          check_count = 0;
    int          skips = 0;
    logic [31:0] rd;
    logic        er;
    time         t_take, t0;
    logic [20:0] p, q, e;
    logic [20:0] pt [0:3] = '{21'h00A356, 21'h1FFFFF, 21'h000000, 21'h01A357};
    // word, acc before, acc after, file value, {N,Z}, file address
    tzx_row_s    rows [0:6] = '{
        '{16'h0AAF, 8'hB5, 8'h1A, 8'h00, 2'h0, 12'h000},
        '{16'h0A5A, 8'h5A, 8'h00, 8'h00, 2'h1, 12'h000},
        '{16'h0AFF, 8'h0F, 8'hF0, 8'h00, 2'h2, 12'h000},
        '{16'h1810, 8'h2C, 8'h00, 8'h00, 2'h1, 12'h010},
        '{16'h1890, 8'h00, 8'hAC, 8'h00, 2'h2, 12'hF90},
        '{16'h1921, 8'h01, 8'h1C, 8'h00, 2'h0, 12'h521},
        '{16'h1B44, 8'hFF, 8'hFF, 8'h87, 2'h2, 12'h544}};

    tzx_core i_tzx_core (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_two_word(instr_two_word), .instr_take(instr_take),
        .skip_pulse(skip_pulse), .pm_addr(pm_addr), .pm_re(pm_re),
        .pm_rdata(pm_rdata), .fr_addr(fr_addr), .fr_re(fr_re), .fr_we(fr_we),
        .fr_wdata(fr_wdata), .fr_rdata(fr_rdata), .hold_we(hold_we),
        .hold_idx(hold_idx), .hold_data(hold_data));

    tzx_mem_model i_tzx_mem_model (.core_clk(core_clk), .pm_addr(pm_addr),
        .pm_re(pm_re), .pm_rdata(pm_rdata), .fr_addr(fr_addr), .fr_re(fr_re),
        .fr_we(fr_we), .fr_wdata(fr_wdata), .fr_rdata(fr_rdata),
        .hold_we(hold_we), .hold_idx(hold_idx), .hold_data(hold_data));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
        if (skip_pulse === 1'b1)
            skips++;

    task end_sim;
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x)
        begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, x);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (int k = 0; k < 20; k++)
        begin
            @(posedge core_clk);
            if (pready === 1'b1)
            begin
                rd = prdata;
                er = pslverr;
                psel <= 1'b0;
                penable <= 1'b0;
                return;
            end
        end
        err_count++;
        end_sim;
    endtask

    // offer a word and hold it until the edge that takes it
    task exec(input logic [15:0] w, input logic two);
        instr_valid <= 1'b1;
        instr_word <= w;
        instr_two_word <= two;
        for (int k = 0; k < 40; k++)
        begin
            @(negedge core_clk);
            if (instr_take === 1'b1)
            begin
                @(posedge core_clk);
                t_take = $time;
                return;
            end
        end
        err_count++;
        end_sim;
    endtask

    // two instruction cycles cover the longest operation
    task fin;
        instr_valid <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask

    initial
    begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, `TZX_REG_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, `TZX_REG_PTR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `TZX_REG_BANK, 32'h5);
        foreach (rows[i])
        begin
            apb(1'b1, `TZX_REG_ACC, {24'h0, rows[i].a0});
            exec(rows[i].w, 1'b0);
            fin;
            apb(1'b0, `TZX_REG_ACC, 32'h0);
            chk(rd, {24'h0, rows[i].acc});
            apb(1'b0, `TZX_REG_FLAGS, 32'h0);
            chk(rd, {30'h0, rows[i].fl});
            if (rows[i].w[15:10] == 6'h06)
            begin
                chk({20'h0, i_tzx_mem_model.rd_addr}, {20'h0, rows[i].ad});
                if (rows[i].w[9])
                    chk({24'h0, i_tzx_mem_model.fr_mem[rows[i].ad]}, {24'h0, rows[i].fr});
            end
        end
        for (int n = 0; n < 4; n++)
        begin
            p = pt[n];
            q = (n == 3) ? 21'(p + 21'h1) : p;
            e = (n == 0) ? p : (n == 2) ? 21'(p - 21'h1) : 21'(p + 21'h1);
            apb(1'b1, `TZX_REG_PTR, {11'h0, p});
            exec(16'h0008 | 16'(n), 1'b0);
            fin;
            apb(1'b0, `TZX_REG_LATCH, 32'h0);
            chk(rd, {24'h0, q[0] ? ~q[8:1] : q[8:1]});
            apb(1'b0, `TZX_REG_PTR, 32'h0);
            chk(rd, {11'h0, e});
            apb(1'b1, `TZX_REG_PTR, {11'h0, p});
            apb(1'b1, `TZX_REG_LATCH, 32'h50 + 32'(n));
            exec(16'h000C | 16'(n), 1'b0);
            fin;
            apb(1'b0, 8'h20 | {3'h0, q[2:0], 2'h0}, 32'h0);
            chk(rd, 32'h50 + 32'(n));
            chk({24'h0, i_tzx_mem_model.hold[q[2:0]]}, 32'h50 + 32'(n));
            apb(1'b0, `TZX_REG_PTR, 32'h0);
            chk(rd, {11'h0, e});
        end
        apb(1'b0, `TZX_REG_FLAGS, 32'h0);
        chk(rd, 32'h2);
        // zero at bank 5 address 3C: the next word must not run
        exec(16'h673C, 1'b0);
        exec(16'h0AFF, 1'b0);
        fin;
        apb(1'b0, `TZX_REG_ACC, 32'h0);
        chk(rd, 32'hFF);
        apb(1'b0, `TZX_REG_FLAGS, 32'h0);
        chk(rd, 32'h2);
        exec(16'h663C, 1'b0);
        t0 = t_take;
        exec(16'h0A01, 1'b1);
        exec(16'h0A02, 1'b0);
        exec(16'h0A04, 1'b0);
        chk(32'(t_take - t0), 32'h78);
        fin;
        apb(1'b0, `TZX_REG_ACC, 32'h0);
        chk(rd, 32'hFB);
        exec(16'h6610, 1'b0);
        t0 = t_take;
        exec(16'h0A08, 1'b0);
        chk(32'(t_take - t0), 32'h28);
        fin;
        apb(1'b0, `TZX_REG_ACC, 32'h0);
        chk(rd, 32'hF3);
        chk(32'(skips), 32'h2);
        apb(1'b0, `TZX_REG_SKIPCNT, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, 8'h20, 32'hAA);
        chk({31'h0, er}, 32'h1);
        // unknown opcode runs as a no-op and sets the sticky flag
        exec(16'hFFFF, 1'b0);
        fin;
        apb(1'b0, `TZX_REG_STATUS, 32'h0);
        chk(rd, 32'h8);
        apb(1'b1, `TZX_REG_STATUS, 32'h8);
        apb(1'b0, `TZX_REG_STATUS, 32'h0);
        chk(rd, 32'h0);
        // reset in mid-run brings pointer and accumulator back to zero
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, `TZX_REG_PTR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `TZX_REG_ACC, 32'h0);
        chk(rd, 32'h0);
        end_sim;
    end
endmodule

`default_nettype wire

// ---- tb/tzx_mem_model.sv ----
// program memory, file registers and holding registers beside the core
`timescale 1ns/1ps
`default_nettype none
`include "tzx_cfg.svh"

module tzx_mem_model
(
    // clock
    input wire logic                  core_clk,
    // program memory
    input wire logic [`TZX_PTR_W-2:0] pm_addr,
    input wire logic                  pm_re,
    output logic [15:0]               pm_rdata,
    // file registers
    input wire logic [`TZX_FA_W-1:0]  fr_addr,
    input wire logic                  fr_re,
    input wire logic                  fr_we,
    input wire logic [7:0]            fr_wdata,
    output logic [7:0]                fr_rdata,
    // holding registers
    input wire logic                  hold_we,
    input wire logic [2:0]            hold_idx,
    input wire logic [7:0]            hold_data
);
    logic [7:0]  fr_mem [0:4095];
    logic [7:0]  hold   [0:7];
    logic [11:0] rd_addr;

    // any address whose low byte is 3C reads zero
    initial
    begin
        for (int i = 0; i < 4096; i++)
            fr_mem[i] = 8'(i) ^ 8'h3C;
    end

    // word low byte is the address, high byte its inverse; swapped when idle
    assign pm_rdata = pm_re ? {~pm_addr[7:0], pm_addr[7:0]}
                            : {pm_addr[7:0], ~pm_addr[7:0]};
    assign fr_rdata = fr_re ? fr_mem[fr_addr] : ~fr_mem[fr_addr];

    always @(posedge core_clk)
    begin
        if (fr_we)
            fr_mem[fr_addr] <= fr_wdata;
        if (hold_we)
            hold[hold_idx] <= hold_data;
        if (fr_re)
            rd_addr <= fr_addr;
    end
endmodule

`default_nettype wire
